// File: logic/drie_defines.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef DRIE_DEFINES_SVH
`define DRIE_DEFINES_SVH

`define DRIE_ADDR_W        12
`define DRIE_ADDR_CTRL     12'h000
`define DRIE_ADDR_CMD      12'h004
`define DRIE_ADDR_DATA     12'h008
`define DRIE_ADDR_STATUS   12'h00c
`define DRIE_ADDR_PEND     12'h010

`define DRIE_CTRL_SMP_EXT  0
`define DRIE_CTRL_CPY_EXT  1
`define DRIE_CTRL_GATED    2
`define DRIE_CTRL_PULSE    3
`define DRIE_CTRL_EDGE_LO  4
`define DRIE_CTRL_EDGE_HI  5
`define DRIE_CTRL_TGT_LO   8
`define DRIE_CTRL_TGT_HI   14

`define DRIE_CMD_SAMPLE    0
`define DRIE_CMD_ENABLE    1
`define DRIE_CMD_DISABLE   2
`define DRIE_CMD_SERVICE   3
`define DRIE_CMD_POLL      4

`define DRIE_STAT_SRQ      6
`define DRIE_STAT_INTR     9

`define DRIE_ALL_CH        7'h5d
`define DRIE_TGT_RST       7'h00
`define DRIE_CH_N          16
`define DRIE_TRIG_IDLE     2'h3

`define DRIE_CLK_NS        5
`define DRIE_PULSE_NS      2000
`define DRIE_PULSE_CYC     (`DRIE_PULSE_NS / `DRIE_CLK_NS)
`define DRIE_PCNT_W        9

`endif

// File: logic/drie_pkg.sv
// Types shared by the dual rank input and edge interrupt logic.
package drie_pkg;

  typedef enum logic [1:0]
  {
    DRIE_EDGE_NONE = 2'h0,
    DRIE_EDGE_RISE = 2'h1,
    DRIE_EDGE_FALL = 2'h2,
    DRIE_EDGE_BOTH = 2'h3
  } drie_edge_t;

  typedef enum logic [1:0]
  {
    DRIE_RD_IDLE = 2'h0,
    DRIE_RD_WAIT = 2'h1,
    DRIE_RD_DONE = 2'h3
  } drie_rd_t;

  typedef struct packed
  {
    logic       smp_ext;
    logic       cpy_ext;
    logic       gated;
    logic       pulse_mode;
    drie_edge_t edge_sel;
    logic [6:0] target;
  } drie_ctrl_t;

  typedef struct packed
  {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] prev;
    logic [1:0]  tsync1;
    logic [1:0]  tsync2;
    logic [1:0]  tprev;
    drie_ctrl_t  ctrl;
    logic [15:0] rank1;
    logic [15:0] rank2;
    logic        fresh;
    logic [15:0] ien;
    logic [15:0] pend;
    logic        intr;
    logic        srq;
    logic        init;
    drie_rd_t    rs;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        lvl;
    logic        smp_out;
    logic        cpy_out_n;
  } drie_st_t;

  typedef struct packed
  {
    logic [8:0] cnt;
  } drie_pulse_st_t;

endpackage

// File: logic/drie_pulse.sv
// Retriggerable pulse timer that stays active for the nominal trigger width.
`timescale 1ns/1ps
`include "drie_defines.svh"

module drie_pulse (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fire,
  output logic      active
);

  drie_pkg::drie_pulse_st_t st_ff;
  drie_pkg::drie_pulse_st_t nxt_st;

  // A new trigger restarts the width, so pulses never merge short.
  always_comb
  begin
    nxt_st = st_ff;
    if (fire)
    begin
      nxt_st.cnt = `DRIE_PCNT_W'(`DRIE_PULSE_CYC);
    end
    else if (st_ff.cnt != '0)
    begin
      nxt_st.cnt = st_ff.cnt - `DRIE_PCNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign active = (st_ff.cnt != '0);

endmodule

// File: logic/drie_core.sv
// Dual rank digital input register with trigger outputs and edge interrupts.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "drie_defines.svh"

module drie_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] channel_in,
  input  wire logic        sample_trigger_input_n,
  input  wire logic        copy_trigger_input_n,
  output logic             sample_trigger_output,
  output logic             copy_trigger_output_n,
  output logic             service_request
);

  localparam drie_pkg::drie_st_t ST_RST = '{
    sync1: '0, sync2: '0, prev: '0,
    tsync1: `DRIE_TRIG_IDLE, tsync2: `DRIE_TRIG_IDLE,
    tprev: `DRIE_TRIG_IDLE,
    ctrl: '{smp_ext: 1'b0, cpy_ext: 1'b0, gated: 1'b0, pulse_mode: 1'b0,
            edge_sel: drie_pkg::DRIE_EDGE_NONE, target: `DRIE_TGT_RST},
    rank1: '0, rank2: '0, fresh: 1'b0, ien: '0, pend: '0,
    intr: 1'b0, srq: 1'b0, init: 1'b1, rs: drie_pkg::DRIE_RD_IDLE,
    pready: 1'b0, pslverr: 1'b0, prdata: '0,
    lvl: 1'b1, smp_out: 1'b1, cpy_out_n: 1'b1
  };

  drie_pkg::drie_st_t st_ff;
  drie_pkg::drie_st_t nxt_st;

  logic        ext_smp;
  logic        ext_cpy;
  logic        acc;
  logic        data_rd;
  logic        go;
  logic        mapped;
  logic [31:0] cmd;
  logic        smp_trig;
  logic        cpy_trig;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] sel;
  logic [15:0] hit;
  logic [15:0] tmask;
  logic [15:0] clr_mask;
  logic        new_int;
  logic [31:0] rd_val;
  logic        smp_active;
  logic        cpy_active;

  drie_pulse u_smp_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (smp_trig),
    .active  (smp_active)
  );

  drie_pulse u_cpy_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (cpy_trig),
    .active  (cpy_active)
  );

  always_comb
  begin
    nxt_st = st_ff;
    // Pins are two-flop synchronised; the edge logic compares stage two with the prev flop behind it.
    nxt_st.sync1  = channel_in;
    nxt_st.sync2  = st_ff.sync1;
    nxt_st.prev   = st_ff.sync2;
    nxt_st.tsync1 = {copy_trigger_input_n, sample_trigger_input_n};
    nxt_st.tsync2 = st_ff.tsync1;
    nxt_st.tprev  = st_ff.tsync2;
    ext_smp = st_ff.tprev[0] & ~st_ff.tsync2[0];
    ext_cpy = st_ff.tprev[1] & ~st_ff.tsync2[1];

    acc     = psel & penable;
    data_rd = !pwrite && (paddr == `DRIE_ADDR_DATA);
    mapped  = (paddr == `DRIE_ADDR_CTRL) || (paddr == `DRIE_ADDR_CMD) ||
              (paddr == `DRIE_ADDR_DATA) || (paddr == `DRIE_ADDR_STATUS) ||
              (paddr == `DRIE_ADDR_PEND);
    // A gated data read holds the bus until a fresh sample is in.
    go = 1'b0;
    if (acc && (st_ff.rs == drie_pkg::DRIE_RD_IDLE))
    begin
      go = !(data_rd && st_ff.ctrl.gated && !st_ff.fresh);
    end
    else if (acc && (st_ff.rs == drie_pkg::DRIE_RD_WAIT))
    begin
      go = st_ff.fresh;
    end
    cmd = (go && pwrite && (paddr == `DRIE_ADDR_CMD)) ? pwdata : '0;

    smp_trig = st_ff.ctrl.smp_ext ? ext_smp
                                  : cmd[`DRIE_CMD_SAMPLE];
    cpy_trig = st_ff.init
             | (st_ff.ctrl.cpy_ext ? ext_cpy
                                   : (go & data_rd));
    nxt_st.init = 1'b0;
    if (smp_trig)
    begin
      nxt_st.rank1 = st_ff.sync2;
    end
    if (cpy_trig)
    begin
      nxt_st.rank2 = st_ff.rank1;
    end
    // Each external sample allows exactly one gated read; set wins.
    nxt_st.fresh = (st_ff.fresh & ~(go & data_rd))
                 | (st_ff.ctrl.smp_ext & ext_smp);

    rise = st_ff.sync2 & ~st_ff.prev;
    fall = ~st_ff.sync2 & st_ff.prev;
    unique case (st_ff.ctrl.edge_sel)
      drie_pkg::DRIE_EDGE_NONE: sel = '0;
      drie_pkg::DRIE_EDGE_RISE: sel = rise;
      drie_pkg::DRIE_EDGE_FALL: sel = fall;
      drie_pkg::DRIE_EDGE_BOTH: sel = rise | fall;
    endcase
    hit = sel & st_ff.ien;

    if (st_ff.ctrl.target == `DRIE_ALL_CH)
    begin
      tmask = '1;
    end
    else if (st_ff.ctrl.target < 7'(`DRIE_CH_N))
    begin
      tmask = 16'h0001 << st_ff.ctrl.target[3:0];
    end
    else
    begin
      tmask = '0;
    end
    clr_mask = '0;
    if (cmd[`DRIE_CMD_SERVICE])
    begin
      clr_mask = '1;
    end
    else if (cmd[`DRIE_CMD_ENABLE] || cmd[`DRIE_CMD_DISABLE])
    begin
      clr_mask = tmask;
    end
    nxt_st.ien = st_ff.ien & ~((cmd[`DRIE_CMD_SERVICE] ||
                                cmd[`DRIE_CMD_DISABLE]) ? clr_mask : '0);
    if (cmd[`DRIE_CMD_ENABLE])
    begin
      nxt_st.ien = nxt_st.ien | tmask;
    end
    // An edge landing on the clearing cycle stays pending.
    nxt_st.pend = (st_ff.pend & ~clr_mask) | hit;
    new_int = |(hit & ~st_ff.pend);
    nxt_st.intr = (st_ff.intr & ~(go && !pwrite &&
                  (paddr == `DRIE_ADDR_STATUS))) | new_int;
    nxt_st.srq = (st_ff.srq & ~cmd[`DRIE_CMD_POLL]) | new_int;

    // The value copied this cycle is what the read must see.
    rd_val = '0;
    unique case (paddr)
      `DRIE_ADDR_CTRL:
      begin
        rd_val[`DRIE_CTRL_SMP_EXT] = st_ff.ctrl.smp_ext;
        rd_val[`DRIE_CTRL_CPY_EXT] = st_ff.ctrl.cpy_ext;
        rd_val[`DRIE_CTRL_GATED]   = st_ff.ctrl.gated;
        rd_val[`DRIE_CTRL_PULSE]   = st_ff.ctrl.pulse_mode;
        rd_val[`DRIE_CTRL_EDGE_HI:`DRIE_CTRL_EDGE_LO] = st_ff.ctrl.edge_sel;
        rd_val[`DRIE_CTRL_TGT_HI:`DRIE_CTRL_TGT_LO]   = st_ff.ctrl.target;
      end
      `DRIE_ADDR_DATA:
        rd_val[15:0] = cpy_trig ? st_ff.rank1 : st_ff.rank2;
      `DRIE_ADDR_STATUS:
      begin
        rd_val[`DRIE_STAT_INTR] = st_ff.intr;
        rd_val[`DRIE_STAT_SRQ]  = st_ff.srq;
      end
      `DRIE_ADDR_PEND:
        rd_val = {st_ff.ien, st_ff.pend};
      default:
        rd_val = '0;
    endcase

    if (go && pwrite && (paddr == `DRIE_ADDR_CTRL))
    begin
      nxt_st.ctrl.smp_ext    = pwdata[`DRIE_CTRL_SMP_EXT];
      nxt_st.ctrl.cpy_ext    = pwdata[`DRIE_CTRL_CPY_EXT];
      nxt_st.ctrl.gated      = pwdata[`DRIE_CTRL_GATED];
      nxt_st.ctrl.pulse_mode = pwdata[`DRIE_CTRL_PULSE];
      nxt_st.ctrl.edge_sel   = drie_pkg::drie_edge_t'(
        pwdata[`DRIE_CTRL_EDGE_HI:`DRIE_CTRL_EDGE_LO]);
      nxt_st.ctrl.target     = pwdata[`DRIE_CTRL_TGT_HI:`DRIE_CTRL_TGT_LO];
    end

    nxt_st.pready = 1'b0;
    unique case (st_ff.rs)
      drie_pkg::DRIE_RD_IDLE,
      drie_pkg::DRIE_RD_WAIT:
      begin
        if (go)
        begin
          nxt_st.rs      = drie_pkg::DRIE_RD_DONE;
          nxt_st.pready  = 1'b1;
          nxt_st.pslverr = !mapped;
          nxt_st.prdata  = (pwrite || !mapped) ? '0 : rd_val;
        end
        else if (acc)
        begin
          nxt_st.rs = drie_pkg::DRIE_RD_WAIT;
        end
      end
      drie_pkg::DRIE_RD_DONE:
      begin
        nxt_st.rs      = drie_pkg::DRIE_RD_IDLE;
        nxt_st.pslverr = 1'b0;
      end
      default:
        nxt_st.rs = drie_pkg::DRIE_RD_IDLE;
    endcase

    if (cpy_trig)
    begin
      nxt_st.lvl = 1'b1;
    end
    else if (smp_trig)
    begin
      nxt_st.lvl = 1'b0;
    end
    nxt_st.smp_out = st_ff.ctrl.pulse_mode ? !smp_active
                                           : st_ff.lvl;
    nxt_st.cpy_out_n = !cpy_active;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata                = st_ff.prdata;
  assign pready                = st_ff.pready;
  assign pslverr               = st_ff.pslverr;
  assign sample_trigger_output = st_ff.smp_out;
  assign copy_trigger_output_n = st_ff.cpy_out_n;
  assign service_request       = st_ff.srq;

  // Helper counter of consecutive low cycles on the copy trigger output.
  logic [9:0] low_cnt_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt_ff <= '0;
    end
    else
    begin
      low_cnt_ff <= st_ff.cpy_out_n ? 10'h000 : low_cnt_ff + 10'h001;
    end
  end

  copy_pulse_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpy_trig |-> ##2 !copy_trigger_output_n)
    else $error("copy pulse did not start");
  copy_pulse_width_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(copy_trigger_output_n) |-> low_cnt_ff >= 10'(`DRIE_PULSE_CYC))
    else $error("copy pulse too short");
  sample_store_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    smp_trig |=> st_ff.rank1 == $past(st_ff.sync2))
    else $error("sample not stored in rank one");
  copy_store_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpy_trig |=> st_ff.rank2 == $past(st_ff.rank1))
    else $error("rank two not copied");
  read_word_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `DRIE_ADDR_DATA && !st_ff.ctrl.cpy_ext
    |-> prdata == {16'h0000, st_ff.rank2})
    else $error("read word differs from rank two");
  gated_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `DRIE_ADDR_DATA && st_ff.ctrl.gated
    |-> $past(st_ff.fresh) && !st_ff.fresh)
    else $error("gated read without fresh sample");
  enable_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 (st_ff.pend & ~$past(st_ff.pend) & ~$past(st_ff.ien)) == '0)
    else $error("pending set on disabled channel");
  flags_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    new_int |=> st_ff.intr && st_ff.srq && service_request)
    else $error("interrupt flags not set");
  level_high_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_ff.ctrl.pulse_mode && cpy_trig ##1 !st_ff.ctrl.pulse_mode
    |=> sample_trigger_output)
    else $error("level output not driven high");

endmodule

// File: tb/drie_far.sv
// Far-side model: channel sources and external trigger pulse drivers.
`timescale 1ns/1ps

module drie_far (
  input  wire logic        pclk,
  output logic      [15:0] channel_in,
  output logic             sample_trigger_input_n,
  output logic             copy_trigger_input_n
);
  initial
  begin
    channel_in             = 16'h0000;
    sample_trigger_input_n = 1'b1;
    copy_trigger_input_n   = 1'b1;
  end

  task automatic set_ch(input logic [15:0] v);
    @(posedge pclk);
    channel_in <= v;
  endtask

  // A 2 us low pulse, the width a neighbouring card sends.
  task automatic fire(input logic cpy);
    @(posedge pclk);
    sample_trigger_input_n <= cpy;
    copy_trigger_input_n   <= ~cpy;
    repeat (400) @(posedge pclk);
    sample_trigger_input_n <= 1'b1;
    copy_trigger_input_n   <= 1'b1;
  endtask
endmodule

// File: tb/dual_rank_input_edge_irq_tb.sv
// Self-checking bench for the dual rank input and edge interrupt block.
`timescale 1ns/1ps
`include "drie_defines.svh"

module dual_rank_input_edge_irq_tb;
  localparam int PW = `DRIE_PULSE_CYC;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] channel_in;
  logic        sample_trigger_input_n;
  logic        copy_trigger_input_n;
  logic        sample_trigger_output;
  logic        copy_trigger_output_n;
  logic        service_request;
  logic [31:0] q;
  logic        err;
  logic        rd_done;
  int          plen;
  int          mismatches;
  int          samples_checked;

  drie_core u_drie_core (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .channel_in             (channel_in),
    .sample_trigger_input_n (sample_trigger_input_n),
    .copy_trigger_input_n   (copy_trigger_input_n),
    .sample_trigger_output  (sample_trigger_output),
    .copy_trigger_output_n  (copy_trigger_output_n),
    .service_request        (service_request)
  );

  drie_far u_drie_far (
    .pclk                   (pclk),
    .channel_in             (channel_in),
    .sample_trigger_input_n (sample_trigger_input_n),
    .copy_trigger_input_n   (copy_trigger_input_n)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Gated reads may wait long; only the watchdog ends a hung wait.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse_len(input logic cpy);
    plen = 0;
    for (int n = 0; n < 1000; n++)
    begin
      @(posedge pclk);
      if ((cpy ? copy_trigger_output_n : sample_trigger_output) === 1'b0)
        plen++;
      else if (plen > 0)
        break;
    end
  endtask

  task automatic t_reset_internal();
    fork
      pulse_len(1'b1);
      apb(1'b0, `DRIE_ADDR_CTRL, 32'h0000_0000);
    join
    check(plen, PW);
    check(q, 32'h0000_0000);
    check({31'h0, sample_trigger_output}, 32'h0000_0001);
    u_drie_far.set_ch(16'h8001);
    repeat (4) @(posedge pclk);
    apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0001);
    fork
      pulse_len(1'b1);
      apb(1'b0, `DRIE_ADDR_DATA, 32'h0000_0000);
    join
    check(q, 32'h0000_8001);
    check(plen, PW);
  endtask

  task automatic t_ext_sample();
    apb(1'b1, `DRIE_ADDR_CTRL, 32'h0000_0009);
    u_drie_far.set_ch(16'h2628);
    fork
      u_drie_far.fire(1'b0);
      pulse_len(1'b0);
    join
    check(plen, PW);
    apb(1'b0, `DRIE_ADDR_DATA, 32'h0000_0000);
    check(q, 32'h0000_2628);
  endtask

  task automatic t_gated();
    apb(1'b1, `DRIE_ADDR_CTRL, 32'h0000_0005);
    u_drie_far.set_ch(16'h0a41);
    u_drie_far.fire(1'b0);
    check({31'h0, sample_trigger_output}, 32'h0000_0000);
    apb(1'b0, `DRIE_ADDR_DATA, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check(q, 32'h0000_0a41);
    check({31'h0, sample_trigger_output}, 32'h0000_0001);
    u_drie_far.set_ch(16'hc002);
    rd_done = 1'b0;
    fork
      begin
        apb(1'b0, `DRIE_ADDR_DATA, 32'h0000_0000);
        rd_done = 1'b1;
      end
      begin
        repeat (40) @(posedge pclk);
        check({31'h0, rd_done}, 32'h0000_0000);
        u_drie_far.fire(1'b0);
      end
    join
    check(q, 32'h0000_c002);
  endtask

  task automatic t_ext_copy();
    apb(1'b1, `DRIE_ADDR_CTRL, 32'h0000_0002);
    u_drie_far.set_ch(16'h1234);
    repeat (4) @(posedge pclk);
    apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0001);
    apb(1'b0, `DRIE_ADDR_DATA, 32'h0000_0000);
    check(q, 32'h0000_c002);
    u_drie_far.fire(1'b1);
    apb(1'b0, `DRIE_ADDR_DATA, 32'h0000_0000);
    check(q, 32'h0000_1234);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({err, q[30:0]}, 32'h8000_0000);
  endtask

  task automatic t_edges();
    logic [1:0] m;
    logic       h;
    for (int i = 0; i < 5; i++)
    begin
      m = (i == 4) ? 2'h3 : i[1:0];
      h = (i == 4) ? 1'b0 : m[0];
      u_drie_far.set_ch(16'h0000);
      repeat (6) @(posedge pclk);
      apb(1'b1, `DRIE_ADDR_CTRL, {17'h0, 7'h03, 2'h0, m, 4'h0});
      if (i < 4)
        apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0002);
      u_drie_far.set_ch(16'h0028);
      repeat (10) @(posedge pclk);
      apb(1'b0, `DRIE_ADDR_PEND, 32'h0000_0000);
      check(q, {12'h0, i < 4, 3'h0, 12'h0, h, 3'h0});
      check({31'h0, service_request}, {31'h0, h});
      u_drie_far.set_ch(16'h0000);
      repeat (10) @(posedge pclk);
      h = (i == 4) ? 1'b0 : |m;
      apb(1'b0, `DRIE_ADDR_STATUS, 32'h0000_0000);
      check(q, {22'h0, h, 2'h0, h, 6'h0});
      apb(1'b0, `DRIE_ADDR_STATUS, 32'h0000_0000);
      check(q, {25'h0, h, 6'h0});
      apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0010);
      check({31'h0, service_request}, 32'h0000_0000);
      apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0004);
      apb(1'b0, `DRIE_ADDR_PEND, 32'h0000_0000);
      check(q, 32'h0000_0000);
    end
    apb(1'b1, `DRIE_ADDR_CTRL, {17'h0, `DRIE_ALL_CH, 2'h0, 2'h3, 4'h0});
    apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0002);
    u_drie_far.set_ch(16'h0080);
    repeat (10) @(posedge pclk);
    apb(1'b0, `DRIE_ADDR_PEND, 32'h0000_0000);
    check(q, 32'hffff_0080);
    apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0002);
    apb(1'b0, `DRIE_ADDR_PEND, 32'h0000_0000);
    check(q, 32'hffff_0000);
    apb(1'b1, `DRIE_ADDR_CMD, 32'h0000_0008);
    apb(1'b0, `DRIE_ADDR_PEND, 32'h0000_0000);
    check(q, 32'h0000_0000);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Runs need about 2800 cycles; 32000 cycles, over ten times that, marks a hang.
  initial
  begin
    #160000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    mismatches      = 0;
    samples_checked = 0;
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_internal();
    t_ext_sample();
    t_gated();
    t_ext_copy();
    t_edges();
    stop_test();
  end
endmodule
